/* File: common/txcp_pkg.sv */
// txcp_pkg: shared constants for the transmit command word parser
// assumes: 32-bit words on the link and an APB register port on the host end
`default_nettype none
package txcp_pkg;
  // command word layout
  localparam int CA_IOC      = 31;  // interrupt on completion
  localparam int CA_RSV_HI   = 30;
  localparam int CA_RSV_LO   = 26;
  localparam int CA_ALN_HI   = 25;  // buffer end alignment
  localparam int CA_ALN_LO   = 24;
  localparam int CA_OFF_HI   = 20;  // data start offset
  localparam int CA_OFF_LO   = 16;
  localparam int CA_FIRST    = 13;
  localparam int CA_LAST     = 12;
  localparam int CA_SIZE_HI  = 10;  // buffer byte count
  localparam int CB_TAG_HI   = 31;
  localparam int CB_TAG_LO   = 16;
  localparam int CB_LEN_HI   = 10;  // packet length
  localparam int SIZE_W      = 11;
  localparam int OFF_W       = 5;
  localparam int TAG_W       = 16;
  localparam int END_W       = 12;  // offset plus size
  localparam int DW_W        = 10;  // words in one buffer
  // end alignment codes
  typedef enum logic [1:0] {
    TXCP_ALN_4  = 2'h0,
    TXCP_ALN_16 = 2'h1,
    TXCP_ALN_32 = 2'h2,
    TXCP_ALN_RS = 2'h3
  } txcp_aln_t;
  localparam logic [DW_W-1:0] ALN4_MASK  = 10'h000;
  localparam logic [DW_W-1:0] ALN16_MASK = 10'h003;
  localparam logic [DW_W-1:0] ALN32_MASK = 10'h007;
  // host register map (byte addresses)
  localparam logic [7:0] REG_DATA = 8'h00;  // write pushes a word to the link
  localparam logic [7:0] REG_STAT = 8'h04;  // sticky events, write one to clear
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_TSTS = 8'h0c;  // last packet status
  localparam int EV_ERR  = 0;
  localparam int EV_DONE = 1;
  localparam int EV_STAT = 2;
  localparam int EV_N    = 3;
  localparam logic [EV_N-1:0] MASK_RST = 3'h0;
endpackage
`default_nettype wire

/* File: common/txcp_if.sv */
// txcp_if: word stream from host to parser, flags and status back
// assumes: both ends on pclk; the testbench binds the two modports
`default_nettype none
interface txcp_if;
  import txcp_pkg::*;
  logic              wvalid;      // host offers a word
  logic [31:0]       wdata;       // command or payload word
  logic              wready;      // parser takes the word
  logic              err_pls;     // transmit_error_flag event
  logic              done_pls;    // buffer_loaded_flag event
  logic              stat_vld;    // packet status pulse
  logic [TAG_W-1:0]  stat_tag;    // tag of that packet
  logic              stat_err;    // packet had an error
  modport dev  (input wvalid, wdata, output wready, err_pls, done_pls,
                stat_vld, stat_tag, stat_err);
  modport host (output wvalid, wdata, input wready, err_pls, done_pls,
                stat_vld, stat_tag, stat_err);
endinterface
`default_nettype wire

/* File: verilog/txcp_span.sv */
// txcp_span: word counts of one buffer from its command word fields
// assumes: pure combinational helper, fields held stable by the caller
`default_nettype none
module txcp_span
  import txcp_pkg::*;
(
  input  wire logic [OFF_W-1:0]  off,       // data start offset
  input  wire logic [SIZE_W-1:0] size,      // buffer byte count
  input  wire logic [1:0]        aln,       // end alignment code
  output logic      [END_W-1:0]  end_b,     // first byte past payload
  output logic      [DW_W-1:0]   total_dw,  // words incl. padding
  output logic                   aln_bad    // reserved alignment code
);
  logic [END_W-1:0] up_b;
  logic [DW_W-1:0]  data_dw;
  logic [DW_W-1:0]  m;

  // padding follows from offset, size and alignment
  always_comb begin
    end_b   = END_W'({1'b0, size}) + END_W'(off);
    up_b    = end_b + 12'h003;
    data_dw = up_b[END_W-1:2];
    aln_bad = 1'b0;
    unique case (txcp_aln_t'(aln))
      TXCP_ALN_4:  m = ALN4_MASK;
      TXCP_ALN_16: m = ALN16_MASK;
      TXCP_ALN_32: m = ALN32_MASK;
      TXCP_ALN_RS: begin
        m       = ALN4_MASK;
        aln_bad = 1'b1;
      end
    endcase
    total_dw = (data_dw + m) & ~m;
  end
endmodule
`default_nettype wire

/* File: verilog/txcp_parser.sv */
// txcp_parser: device end, splits command words from payload and checks packets
// assumes: host end drives the stream on the same pclk; payload sink may stall
//
// Our own choices: the APB interface to the registers and the register offsets.
`default_nettype none
module txcp_parser
  import txcp_pkg::*;
(
  input  wire logic        pclk,       // system clock
  input  wire logic        presetn,    // async reset, active low
  input  wire logic        pclk_en,    // freezes all state when low
  txcp_if.dev              lnk,        // word stream from the host end
  output logic             pay_valid,  // payload word available
  output logic [31:0]      pay_data,   // payload word
  output logic [3:0]       pay_be,     // valid bytes of the word
  output logic             pay_last,   // last payload word of a packet
  input  wire logic        pay_ready   // sink takes the word
);
  typedef enum logic [1:0] {TXCP_CMDA, TXCP_CMDB, TXCP_DATA} txcp_st_t;

  txcp_st_t          st_r;
  logic              ioc_r;
  logic              last_r;
  logic [OFF_W-1:0]  off_r;
  logic [SIZE_W-1:0] size_r;
  logic [1:0]        aln_r;
  logic [31:0]       cb_first_r;   // second word of the packet's first buffer
  logic              open_r;       // a packet is in progress
  logic              perr_r;       // error seen in this packet
  logic [SIZE_W:0]   sum_r;        // running byte count of the packet
  logic [DW_W-1:0]   widx_r;       // word index inside the buffer
  logic              wready_r;
  logic              err_r;
  logic              done_r;
  logic              svld_r;
  logic [TAG_W-1:0]  stag_r;
  logic              serr_r;
  logic              pv_r;
  logic [31:0]       pd_r;
  logic [3:0]        pbe_r;
  logic              pl_r;
  logic [END_W-1:0]  end_b;
  logic [DW_W-1:0]   total_dw;
  logic              aln_bad;
  logic              take;
  logic [3:0]        be_now;
  logic              is_end;
  logic              pv_nxt;
  logic [SIZE_W:0]   sum_nxt;
  logic              bmis;
  logic              lmis;

  // byte lanes of word idx that lie inside [off, end)
  function automatic logic [3:0] lane_en(input logic [DW_W-1:0] idx,
                                         input logic [OFF_W-1:0] off,
                                         input logic [END_W-1:0] eb);
    logic [END_W-1:0] p;
    logic [3:0]       e;
    e = 4'h0;
    for (int j = 0; j < 4; j++) begin
      p    = {idx, 2'h0} + END_W'(j);
      e[j] = (p >= END_W'(off)) && (p < eb);
    end
    return e;
  endfunction

  txcp_span u_span (
    .off      (off_r),
    .size     (size_r),
    .aln      (aln_r),
    .end_b    (end_b),
    .total_dw (total_dw),
    .aln_bad  (aln_bad)
  );

  // ===========================================================
  // stream decode
  // ===========================================================
  always_comb begin
    take    = lnk.wvalid && wready_r;
    be_now  = lane_en(widx_r, off_r, end_b);
    is_end  = (widx_r + 10'h001) >= total_dw;
    // a buffer with no reference loaded starts a fresh byte count
    sum_nxt = (open_r ? sum_r : '0) + (SIZE_W+1)'(size_r);
    bmis    = open_r && (lnk.wdata != cb_first_r);
    lmis    = sum_nxt != (SIZE_W+1)'(lnk.wdata[CB_LEN_HI:0]);
    pv_nxt  = pv_r && !pay_ready;
    if (take && st_r == TXCP_DATA && be_now != 4'h0) begin
      pv_nxt = 1'b1;  // only words with payload lanes are stored downstream
    end
  end

  // command and buffer state machine; commands precede payload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= TXCP_CMDA;
      ioc_r  <= 1'b0;
      last_r <= 1'b0;
      off_r  <= '0;
      size_r <= '0;
      aln_r  <= 2'h0;
      widx_r <= '0;
    end else if (pclk_en && take) begin
      unique case (st_r)
        TXCP_CMDA: begin
          ioc_r  <= lnk.wdata[CA_IOC];
          aln_r  <= lnk.wdata[CA_ALN_HI:CA_ALN_LO];
          off_r  <= lnk.wdata[CA_OFF_HI:CA_OFF_LO];
          last_r <= lnk.wdata[CA_LAST];
          size_r <= lnk.wdata[CA_SIZE_HI:0];
          widx_r <= '0;
          st_r   <= TXCP_CMDB;
        end
        TXCP_CMDB: begin
          st_r <= (total_dw == '0) ? TXCP_CMDA : TXCP_DATA;
        end
        TXCP_DATA: begin
          widx_r <= widx_r + 10'h001;
          if (is_end) begin
            st_r <= TXCP_CMDA;
          end
        end
        default: begin
          st_r <= TXCP_CMDA;  // unused code falls back to a command word
        end
      endcase
    end
  end

  // packet bookkeeping: first word two, running size, error accumulation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_first_r <= '0;
      open_r     <= 1'b0;
      perr_r     <= 1'b0;
      sum_r      <= '0;
    end else if (pclk_en && take && st_r == TXCP_CMDA) begin
      if (lnk.wdata[CA_FIRST]) begin
        open_r <= 1'b0;  // next word two becomes the reference
        perr_r <= 1'b0;
        sum_r  <= '0;
      end
    end else if (pclk_en && take && st_r == TXCP_CMDB) begin
      if (!open_r) begin
        cb_first_r <= lnk.wdata;   // first buffer sets the reference
        open_r     <= 1'b1;
      end
      sum_r  <= sum_nxt;
      perr_r <= (open_r && perr_r) || bmis || aln_bad;
      if (last_r) begin
        open_r <= 1'b0;
      end
    end
  end

  // flag and status pulses toward the host end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r  <= 1'b0;
      done_r <= 1'b0;
      svld_r <= 1'b0;
      stag_r <= '0;
      serr_r <= 1'b0;
    end else if (pclk_en) begin
      err_r  <= 1'b0;
      done_r <= 1'b0;
      svld_r <= 1'b0;
      if (take && st_r == TXCP_CMDB) begin
        // a mismatch is flagged at once so software sees it early
        err_r <= bmis || aln_bad || (last_r && lmis);
        if (total_dw == '0) begin
          done_r <= ioc_r;
        end
        if (last_r) begin
          svld_r <= 1'b1;
          stag_r <= open_r ? cb_first_r[CB_TAG_HI:CB_TAG_LO]
                           : lnk.wdata[CB_TAG_HI:CB_TAG_LO];
          serr_r <= perr_r || bmis || aln_bad || lmis;
        end
      end
      if (take && st_r == TXCP_DATA && is_end) begin
        done_r <= ioc_r;  // buffer fully loaded, padding included
      end
    end
  end

  // payload output register; padding and offset words are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pv_r     <= 1'b0;
      pd_r     <= '0;
      pbe_r    <= 4'h0;
      pl_r     <= 1'b0;
      wready_r <= 1'b0;
    end else if (pclk_en) begin
      pv_r <= pv_nxt;
      // one word in flight keeps ready registered at half rate
      wready_r <= !pv_nxt;
      if (take && st_r == TXCP_DATA && be_now != 4'h0) begin
        pd_r  <= lnk.wdata;
        pbe_r <= be_now;
        pl_r  <= last_r && (widx_r + 10'h001 >= end_b[END_W-1:2] + DW_W'(|end_b[1:0]));
      end
    end
  end

  assign lnk.wready   = wready_r;
  assign lnk.err_pls  = err_r;
  assign lnk.done_pls = done_r;
  assign lnk.stat_vld = svld_r;
  assign lnk.stat_tag = stag_r;
  assign lnk.stat_err = serr_r;
  assign pay_valid    = pv_r;
  assign pay_data     = pd_r;
  assign pay_be       = pbe_r;
  assign pay_last     = pl_r;
endmodule
`default_nettype wire

/* File: verilog/txcp_host.sv */
// txcp_host: host end, APB slave that pushes words and gathers parser events
// assumes: parser end on the same pclk; APB master holds a request until pready
`default_nettype none
module txcp_host
  import txcp_pkg::*;
(
  input  wire logic        pclk,     // system clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic        pclk_en,  // freezes all state when low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb direction
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error on unmapped address
  output logic             irq,      // level interrupt
  txcp_if.host             lnk       // word stream toward the parser
);
  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  logic             irq_r;
  logic             wvalid_r;
  logic [31:0]      wdata_r;
  logic [EV_N-1:0]  stat_r;
  logic [EV_N-1:0]  mask_r;
  logic [TAG_W:0]   tsts_r;
  logic [EV_N-1:0]  ev;
  logic             acc;
  logic             done_x;
  logic             is_data;
  logic             mapped;

  always_comb begin
    acc     = psel && penable;
    done_x  = acc && pready_r;
    is_data = paddr == REG_DATA;
    mapped  = is_data || paddr == REG_STAT || paddr == REG_MASK || paddr == REG_TSTS;
    ev      = '0;
    ev[EV_ERR]  = lnk.err_pls;
    ev[EV_DONE] = lnk.done_pls;
    ev[EV_STAT] = lnk.stat_vld;
  end

  // ===========================================================
  // apb slave
  // ===========================================================
  // a data write waits on the parser, so back-pressure shows as a long access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
      wvalid_r  <= 1'b0;
      wdata_r   <= '0;
    end else if (pclk_en) begin
      pready_r <= 1'b0;
      if (wvalid_r && lnk.wready) begin
        wvalid_r <= 1'b0;
        pready_r <= 1'b1;
      end else if (acc && !pready_r && !wvalid_r) begin
        pslverr_r <= !mapped;
        prdata_r  <= '0;
        if (is_data && pwrite) begin
          wvalid_r <= 1'b1;  // command words and payload alike
          wdata_r  <= pwdata;
        end else begin
          pready_r <= 1'b1;
          if (!pwrite && paddr == REG_STAT) prdata_r <= 32'(stat_r);
          if (!pwrite && paddr == REG_MASK) prdata_r <= 32'(mask_r);
          if (!pwrite && paddr == REG_TSTS) prdata_r <= 32'(tsts_r);
        end
      end
    end
  end

  // sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else if (pclk_en) begin
      if (done_x && pwrite && paddr == REG_STAT) begin
        stat_r <= (stat_r & ~pwdata[EV_N-1:0]) | ev;
      end else begin
        stat_r <= stat_r | ev;
      end
    end
  end

  // mask, last status word and interrupt level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= MASK_RST;
      tsts_r <= '0;
      irq_r  <= 1'b0;
    end else if (pclk_en) begin
      if (done_x && pwrite && paddr == REG_MASK) begin
        mask_r <= pwdata[EV_N-1:0];
      end
      if (lnk.stat_vld) begin
        tsts_r <= {lnk.stat_err, lnk.stat_tag};  // tag returned for matching
      end
      irq_r <= |(stat_r & mask_r);
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign irq        = irq_r;
  assign lnk.wvalid = wvalid_r;
  assign lnk.wdata  = wdata_r;
endmodule
`default_nettype wire

/* File: tb/txcp_chk_sva.sv */
// txcp_chk_sva: parse and timing checks on the link between host end and parser
// assumes: sits beside the interface in the bench, one clock domain
`default_nettype none
module txcp_chk
  import txcp_pkg::*;
(
  input wire logic             pclk,      // system clock
  input wire logic             presetn,   // async reset, active low
  input wire logic             wvalid,    // word offered
  input wire logic [31:0]      wdata,     // offered word
  input wire logic             wready,    // word taken
  input wire logic             err_pls,   // error event
  input wire logic             done_pls,  // loaded event
  input wire logic             stat_vld,  // status pulse
  input wire logic [TAG_W-1:0] stat_tag,  // status tag
  input wire logic             stat_err   // status error
);
  // ======================================================
  // shadow parse of the word stream
  logic [1:0]      ph_r;
  logic [DW_W-1:0] cnt_r;
  logic [DW_W-1:0] n_dw;
  logic [31:0]     a_r;
  logic [31:0]     b1_r;
  logic [11:0]     sum_r;
  logic [11:0]     tot;
  logic [11:0]     e_b;
  logic            open_r;
  logic            done_q;
  logic            stat_q;
  logic            bad_q;
  logic            acc;
  logic            acc_b;
  // word count of a buffer; reserved alignment is left unrounded like 4-byte
  always_comb begin
    e_b  = 12'(a_r[CA_OFF_HI:CA_OFF_LO]) + 12'(a_r[CA_SIZE_HI:0]);
    n_dw = DW_W'((e_b + 12'h3) >> 2);
    if (a_r[CA_ALN_HI:CA_ALN_LO] == 2'h1) n_dw = (n_dw + ALN16_MASK) & ~ALN16_MASK;
    if (a_r[CA_ALN_HI:CA_ALN_LO] == 2'h2) n_dw = (n_dw + ALN32_MASK) & ~ALN32_MASK;
    tot  = ((a_r[CA_FIRST] || !open_r) ? 12'h0 : sum_r) + 12'(a_r[CA_SIZE_HI:0]);
  end
  assign acc   = wvalid && wready;
  assign acc_b = acc && (ph_r == 2'h1);
  // phase, counts and the first buffer's second word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r   <= 2'h0;
      cnt_r  <= '0;
      a_r    <= 32'h0;
      b1_r   <= 32'h0;
      sum_r  <= 12'h0;
      open_r <= 1'b0;
    end else if (acc) begin
      case (ph_r)
        2'h0: begin
          a_r  <= wdata;
          ph_r <= 2'h1;
        end
        2'h1: begin
          ph_r   <= (n_dw == 0) ? 2'h0 : 2'h2;
          cnt_r  <= n_dw;
          sum_r  <= tot;
          open_r <= !a_r[CA_LAST];
          if (a_r[CA_FIRST] || !open_r) b1_r <= wdata;
        end
        default: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == 1) ph_r <= 2'h0;
        end
      endcase
    end
  end
  // events expected one edge after their cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      stat_q <= 1'b0;
      bad_q  <= 1'b0;
    end else begin
      done_q <= a_r[CA_IOC] && ((acc && ph_r == 2'h2 && cnt_r == 1) || (acc_b && n_dw == 0));
      stat_q <= acc_b && a_r[CA_LAST];
      bad_q  <= acc_b && (a_r[CA_ALN_HI:CA_ALN_LO] == 2'h3
                || (open_r && !a_r[CA_FIRST] && wdata != b1_r)
                || (a_r[CA_LAST] && tot != 12'(wdata[CB_LEN_HI:0])));
    end
  end
  // ======================================================
  // assertions
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_stall; wvalid && !wready; endsequence
  sequence s_last_b; acc_b && a_r[CA_LAST]; endsequence
  AST_HOLD: assert property (s_stall |=> wvalid && $stable(wdata))
    else $error("word changed before it was taken");
  AST_DONE: assert property (done_pls == done_q)
    else $error("loaded flag at wrong time");
  AST_STAT: assert property (stat_vld == stat_q)
    else $error("status pulse at wrong time");
  // the packet's tag is the one of its first buffer's second word
  AST_TAG: assert property (s_last_b |=> stat_tag == b1_r[CB_TAG_HI:CB_TAG_LO])
    else $error("status tag differs from second word");
  AST_ALN: assert property (acc_b && a_r[CA_ALN_HI:CA_ALN_LO] == 2'h3 |=> err_pls)
    else $error("reserved alignment not flagged");
  AST_BDIFF: assert property (acc_b && open_r && !a_r[CA_FIRST] && wdata != b1_r |=> err_pls)
    else $error("differing second word not flagged");
  AST_LEN: assert property ((s_last_b ##0 tot != 12'(wdata[CB_LEN_HI:0])) |=> err_pls)
    else $error("length mismatch not flagged");
  AST_CAUSE: assert property (err_pls |-> bad_q)
    else $error("error flag without cause");
endmodule
`default_nettype wire

/* File: tb/txcp_bench.sv */
// txcp_bench: writes buffers over apb into the host end, collects parser payload
// assumes: both ends joined by txcp_if on one 50 mhz clock
`default_nettype none
module txcp_bench import txcp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic        pay_valid, pay_last, pay_ready;
  logic [7:0]  paddr;
  logic [3:0]  pay_be;
  logic [31:0] pwdata, prdata, pay_data, rd;
  logic [36:0] q[$];
  int          err_count, checked;

  txcp_if txcp_if_i ();
  txcp_parser txcp_parser_i (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .lnk(txcp_if_i),
    .pay_valid(pay_valid), .pay_data(pay_data), .pay_be(pay_be), .pay_last(pay_last),
    .pay_ready(pay_ready));
  txcp_host txcp_host_i (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .lnk(txcp_if_i));
  txcp_chk txcp_chk_i (.pclk(pclk), .presetn(presetn), .wvalid(txcp_if_i.wvalid),
    .wdata(txcp_if_i.wdata), .wready(txcp_if_i.wready), .err_pls(txcp_if_i.err_pls),
    .done_pls(txcp_if_i.done_pls), .stat_vld(txcp_if_i.stat_vld),
    .stat_tag(txcp_if_i.stat_tag), .stat_err(txcp_if_i.stat_err));

  // ======================================================
  // clock, stalling sink and payload monitor
  always #10 pclk = ~pclk;
  always @(posedge pclk) pay_ready <= ~pay_ready;
  always @(posedge pclk) if (pay_valid && pay_ready) q.push_back({pay_last, pay_be, pay_data});

  // ======================================================
  // helpers
  task automatic end_sim;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [36:0] g, input logic [36:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) err_count++;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // reserved fields always written as zero
  function automatic logic [31:0] fa(logic i, logic [1:0] al, logic [4:0] of, logic f,
                                     logic l, logic [10:0] sz);
    return {i, 5'h0, al, 3'h0, of, 2'h0, f, l, 1'b0, sz};
  endfunction
  function automatic logic [31:0] fb(logic [15:0] t, logic [10:0] len);
    return {t, 5'h0, len};
  endfunction
  function automatic logic [31:0] pw(int i);
    return 32'h11111111 * (i + 1);
  endfunction
  // commands first, then payload and padding words
  task automatic sbuf(input logic [31:0] a, input logic [31:0] b, input int n);
    apb(1'b1, REG_DATA, a);
    apb(1'b1, REG_DATA, b);
    for (int i = 0; i < n; i++) apb(1'b1, REG_DATA, pw(i));
  endtask

  // ======================================================
  // watchdog, far above the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    end_sim;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pay_ready = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(REG_MASK, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd, er}, 33'h1);
    // single word buffer with completion flag
    sbuf(fa(1'b1, 2'h0, 5'd0, 1'b1, 1'b1, 11'd4), fb(16'h1234, 11'd4), 1);
    rchk(REG_STAT, 32'h6);
    chk(q[0], {1'b1, 4'hf, pw(0)});
    rchk(REG_TSTS, 32'h1234);
    chk(irq, 1'b0);
    apb(1'b1, REG_MASK, 32'h2);
    rchk(REG_STAT, 32'h6);
    chk(irq, 1'b1);
    apb(1'b1, REG_STAT, 32'h7);
    rchk(REG_STAT, 32'h0);
    chk(irq, 1'b0);
    q.delete();
    // offset 3 size 6 at 16-byte end, then a two-buffer packet, first buffer at 32-byte end, second at 4-byte end
    sbuf(fa(1'b0, 2'h1, 5'd3, 1'b1, 1'b1, 11'd6), fb(16'h2, 11'd6), 4);
    sbuf(fa(1'b0, 2'h2, 5'd0, 1'b1, 1'b0, 11'd8), fb(16'h3, 11'd12), 8);
    sbuf(fa(1'b0, 2'h0, 5'd0, 1'b0, 1'b1, 11'd4), fb(16'h3, 11'd12), 1);
    rchk(REG_STAT, 32'h4);
    rchk(REG_TSTS, 32'h3);
    chk(q.size(), 6);
    chk(q[0], {1'b0, 4'h8, pw(0)});
    chk(q[1], {1'b0, 4'hf, pw(1)});
    chk(q[2], {1'b1, 4'h1, pw(2)});
    chk(q[3], {1'b0, 4'hf, pw(0)});
    chk(q[4], {1'b0, 4'hf, pw(1)});
    chk(q[5], {1'b1, 4'hf, pw(0)});
    // faulty packets: reserved alignment, wrong length, differing second word
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, REG_STAT, 32'h7);
      if (k == 2) sbuf(fa(1'b0, 2'h0, 5'd0, 1'b1, 1'b0, 11'd4), fb(16'h9, 11'd8), 1);
      sbuf(fa(1'b0, (k == 0) ? 2'h3 : 2'h0, 5'd0, k != 2, 1'b1, 11'd4),
           fb(16'h8, 11'((k == 2) ? 8 : 4 + k)), 1);
      rchk(REG_STAT, 32'h5);
      apb(1'b0, REG_TSTS, 32'h0);
      chk(rd[16], 1'b1);
    end
    end_sim;
  end
endmodule
`default_nettype wire
